// *** pcsi_core.sv ***
// program counter, return stack and indirect addressing unit
// Functional notes
// - counter is 13 bits; low byte register is read and written by software
// - upper five counter bits are unreadable, written by software only through the high latch
// - every reset clears the upper counter bits
// - low byte write loads upper counter bits from latch bits 4..0
// - call or jump takes 11 target bits plus latch bits 4 and 3
// - eight-entry 13-bit stack, outside memory space, pointer hidden
// - calls and interrupt vectoring push the counter
// - plain return, literal return and interrupt return pop the counter
// - push and pop leave the high latch unchanged
// - stack wraps circularly; ninth push overwrites first entry
// - no overflow or underflow indication exists
// - counter spans 8K words in four 2K pages
// - returns restore the full 13-bit counter from the stack
// - indirect port has no storage; access goes to pointer target
// - indirect read of the port through itself returns zero
// - indirect write of the port through itself changes nothing
// - indirect address is bank bit joined above the 8-bit pointer
// - bank bit set selects 100h-1FFh, clear selects 00h-FFh
`timescale 1ns/1ps
`default_nettype none
`include "pcsi_cfg.svh"
module pcsi_core
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire pcsi_pkg::pcsi_flow_type flow,
  input wire pcsi_pkg::pcsi_wr_type wr,
  input wire pcsi_pkg::pcsi_ind_type ind,
  input wire logic [7:0] ind_target_rdata,
  output logic [12:0] pc_r,
  output logic [7:0] pc_low_byte_register_r,
  output logic [7:0] pc_high_latch_r,
  output logic [7:0] file_select_pointer_r,
  output logic indirect_bank_select_r,
  output logic [8:0] ind_addr_r,
  output logic ind_rd_en_r,
  output logic ind_wr_en_r,
  output logic [7:0] ind_rdata_r
);
  import pcsi_pkg::*;

  // joins bank bit above the pointer into a data address
  function automatic logic [8:0] join_addr(input logic bank, input logic [7:0] ptr);
    join_addr = {bank, ptr};
  endfunction

  logic [12:0] pc_nxt;
  logic [12:0] pc_inc;
  logic [12:0] pc_lowwr;
  logic [12:0] pc_jump;
  logic [12:0] stack_top;
  logic push;
  logic pop;
  logic [8:0] eff_addr;
  logic self_ref;
  logic [7:0] latch_nxt;
  logic op_call;
  logic op_intvec;
  logic op_ret_any;
  logic [12:0] push_val;

  // sequential, low-byte write and jump forms of the next counter
  assign pc_inc = pc_r + 13'h0001;
  assign pc_lowwr = {pc_high_latch_r[4:0], wr.wdata};
  assign pc_jump = {pc_high_latch_r[`PCSI_PAGE_BIT_HI:`PCSI_PAGE_BIT_LO],
                    flow.target};

  // operation decode; a low byte write overrides the flow operation, stack included
  assign op_call = !wr.low_we && (flow.op == PCSI_OP_CALL);
  assign op_intvec = !wr.low_we && (flow.op == PCSI_OP_INTVEC);
  assign op_ret_any = !wr.low_we
                      && ((flow.op == PCSI_OP_RET) || (flow.op == PCSI_OP_RETLIT)
                      || (flow.op == PCSI_OP_RETINT));

  // stack actions
  assign push = op_call || op_intvec;
  assign pop = op_ret_any;

  // call saves the following address, interrupt entry the interrupted one
  assign push_val = op_intvec ? pc_r : pc_inc;

  // latch only changes on a software write, never on push or pop
  assign latch_nxt = wr.latch_we ? wr.wdata : pc_high_latch_r;

  // indirect addressing decode
  assign eff_addr = join_addr(indirect_bank_select_r, file_select_pointer_r);
  assign self_ref = (eff_addr == `PCSI_INDIRECT_PORT_ADDR)
                    || (file_select_pointer_r == `PCSI_PTR_RESET);

  // next counter selection; low byte write has priority over sequencing
  always_comb
  begin
    pc_nxt = pc_r;
    if (wr.low_we)
      pc_nxt = pc_lowwr;
    else
    begin
      case (flow.op)
        PCSI_OP_NEXT: pc_nxt = pc_inc;
        PCSI_OP_JUMP: pc_nxt = pc_jump;
        PCSI_OP_CALL: pc_nxt = pc_jump;
        PCSI_OP_RET: pc_nxt = stack_top;
        PCSI_OP_RETLIT: pc_nxt = stack_top;
        PCSI_OP_RETINT: pc_nxt = stack_top;
        PCSI_OP_INTVEC: pc_nxt = flow.vector;
        PCSI_OP_HOLD: pc_nxt = pc_r;
        default: pc_nxt = pc_r;
      endcase
    end
  end

  // return stack; calls push the address of the next instruction, interrupt entry the interrupted one
  pcsi_stack u_stack
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .push(push),
    .pop(pop),
    .push_data(push_val),
    .top_data(stack_top)
  );

  // program counter; reset clears all bits including the upper ones
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pc_r <= `PCSI_PC_RESET;
    else if (ce)
      pc_r <= pc_nxt;
  end

  // software visible low byte mirrors the counter low byte
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pc_low_byte_register_r <= 8'h00;
    else if (ce)
      pc_low_byte_register_r <= pc_nxt[7:0];
  end

  // high latch register
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      pc_high_latch_r <= 8'h00;
    else if (ce)
      pc_high_latch_r <= latch_nxt;
  end

  // pointer and bank select
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      file_select_pointer_r <= `PCSI_PTR_RESET;
      indirect_bank_select_r <= 1'b0;
    end
    else if (ce)
    begin
      if (wr.ptr_we)
        file_select_pointer_r <= wr.wdata;
      if (wr.bank_we)
        indirect_bank_select_r <= wr.wdata[0];
    end
  end

  // indirect access outputs; self reference reads zero and writes nothing
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ind_addr_r <= 9'h000;
      ind_rd_en_r <= 1'b0;
      ind_wr_en_r <= 1'b0;
      ind_rdata_r <= 8'h00;
    end
    else if (ce)
    begin
      ind_addr_r <= eff_addr;
      ind_rd_en_r <= ind.ind_rd && !self_ref;
      ind_wr_en_r <= ind.ind_wr && !self_ref;
      ind_rdata_r <= self_ref ? `PCSI_READ_ZERO : ind_target_rdata;
    end
  end

  // reset leaves the upper counter bits clear
  a_reset_clears_pc: assert property (@(posedge clk_sys)
    $rose(arst_n) |-> pc_r[12:8] == 5'h00)
    else $error("upper counter bits not cleared by reset");
  // low byte write pulls the upper bits from the latch
  a_low_write_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && wr.low_we |=> pc_r == {$past(pc_high_latch_r[4:0]), $past(wr.wdata)})
    else $error("low byte write did not load counter");
  // software view of the low byte never drifts from the counter
  a_low_mirror: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pc_low_byte_register_r == pc_r[7:0])
    else $error("low byte register differs from counter");

  // jump keeps the page bits of the latch
  a_jump_page_bits: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_JUMP
    |=> pc_r == {$past(pc_high_latch_r[4:3]), $past(flow.target)})
    else $error("jump target formed wrongly");
  // call uses the same target form as a jump
  a_call_target: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_CALL
    |=> pc_r == {$past(pc_high_latch_r[4:3]), $past(flow.target)})
    else $error("call target formed wrongly");

  // return right after a call lands on the call site plus one
  a_call_return_pair: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_CALL && !wr.latch_we
    ##1 ce && !wr.low_we && flow.op == PCSI_OP_RET
    |=> pc_r == $past(pc_r, 2) + 13'h0001)
    else $error("return did not restore call site");
  // interrupt return right after vectoring resumes the interrupted address
  a_int_return: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_INTVEC
    ##1 ce && !wr.low_we && flow.op == PCSI_OP_RETINT
    |=> pc_r == $past(pc_r, 2))
    else $error("interrupt return did not restore counter");
  // vectoring loads the supplied vector address
  a_vector_load: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_INTVEC |=> pc_r == $past(flow.vector))
    else $error("interrupt vector not loaded");
  // a pushed address is on top of the stack one cycle later
  a_push_top: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && push |=> stack_top == $past(push_val))
    else $error("pushed address not on top of stack");
  // stack traffic never disturbs the latch
  a_latch_kept_stack: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && (push || pop) && !wr.latch_we |=> $stable(pc_high_latch_r))
    else $error("stack action changed the high latch");

  // plain sequencing adds one across the full width
  a_seq_increment: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && !wr.low_we && flow.op == PCSI_OP_NEXT |=> pc_r == $past(pc_r) + 13'h0001)
    else $error("sequential flow did not increment");
  // clock enable low freezes counter and latch
  a_freeze_ce: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !ce |=> $stable(pc_r) && $stable(pc_high_latch_r))
    else $error("state changed with clock enable low");

  // ordinary indirect read passes the target data through
  a_rd_forward: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && ind.ind_rd && file_select_pointer_r != 8'h00
    |=> ind_rd_en_r && ind_rdata_r == $past(ind_target_rdata))
    else $error("indirect read not forwarded");
  // self reference reads zero
  a_self_read_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && file_select_pointer_r == 8'h00 && ind.ind_rd |=> ind_rdata_r == 8'h00)
    else $error("self-indirect read not zero");
  // self reference writes nothing
  a_self_write_none: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && file_select_pointer_r == 8'h00 |=> !ind_wr_en_r)
    else $error("self-indirect write reached a register");
  // address is the bank bit above the pointer
  a_addr_join: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce |=> ind_addr_r == {$past(indirect_bank_select_r), $past(file_select_pointer_r)})
    else $error("indirect address not joined correctly");

  // main scenarios
  c_call_ret: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ce && flow.op == PCSI_OP_CALL ##[1:20] ce && flow.op == PCSI_OP_RET);
  c_int_return: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ce && flow.op == PCSI_OP_INTVEC ##[1:20] ce && flow.op == PCSI_OP_RETINT);
  c_low_write: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ce && wr.low_we);
  c_self_read: cover property (@(posedge clk_sys) disable iff (!arst_n)
    ce && ind.ind_rd && self_ref);
  c_stack_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && flow.op == PCSI_OP_CALL) [*8]);
endmodule
`default_nettype wire

// *** pcsi_cfg.svh ***
// constants for the program counter, return stack and indirect addressing unit
`ifndef PCSI_CFG_SVH
`define PCSI_CFG_SVH
`define PCSI_PC_W 13
`define PCSI_HI_W 5
`define PCSI_JUMP_W 11
`define PCSI_STACK_DEPTH 8
`define PCSI_SP_W 3
`define PCSI_DADDR_W 9
`define PCSI_PC_RESET 13'h0000
`define PCSI_PTR_RESET 8'h00
`define PCSI_READ_ZERO 8'h00
`define PCSI_INDIRECT_PORT_ADDR 9'h000
`define PCSI_PAGE_BIT_HI 4
`define PCSI_PAGE_BIT_LO 3
`endif

// *** pcsi_pkg.sv ***
// types for the program counter, return stack and indirect addressing unit
package pcsi_pkg;
  // program flow operation of the current instruction cycle
  typedef enum logic [2:0]
  {
    PCSI_OP_NEXT = 3'b000,
    PCSI_OP_JUMP = 3'b001,
    PCSI_OP_CALL = 3'b010,
    PCSI_OP_RET = 3'b011,
    PCSI_OP_RETLIT = 3'b100,
    PCSI_OP_RETINT = 3'b101,
    PCSI_OP_INTVEC = 3'b110,
    PCSI_OP_HOLD = 3'b111
  } pcsi_op_type;

  // flow command from the instruction decoder
  typedef struct packed
  {
    pcsi_op_type op;
    logic [10:0] target;
    logic [12:0] vector;
  } pcsi_flow_type;

  // software write strobes to the addressing registers
  typedef struct packed
  {
    logic low_we;
    logic latch_we;
    logic ptr_we;
    logic bank_we;
    logic [7:0] wdata;
  } pcsi_wr_type;

  // indirect data access request
  typedef struct packed
  {
    logic ind_rd;
    logic ind_wr;
  } pcsi_ind_type;
endpackage

// *** pcsi_stack.sv ***
// eight-entry circular return-address stack
`timescale 1ns/1ps
`default_nettype none
`include "pcsi_cfg.svh"
module pcsi_stack
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [12:0] push_data,
  output logic [12:0] top_data
);
  import pcsi_pkg::*;
  logic [12:0] mem [0:7];
  logic [2:0] sp_r;
  logic [2:0] sp_nxt;
  logic [2:0] rd_idx;

  // pointer wraps freely, no overflow or underflow status exists
  assign sp_nxt = push ? sp_r + 3'h1 : (pop ? sp_r - 3'h1 : sp_r);
  assign rd_idx = sp_r - 3'h1;
  assign top_data = mem[rd_idx];

  // pointer register, not visible to software
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      sp_r <= 3'h0;
    else if (ce)
      sp_r <= sp_nxt;
  end

  // entry storage, ninth push overwrites the first
  always_ff @(posedge clk_sys)
  begin
    if (ce && push)
      mem[sp_r] <= push_data;
  end

  // pointer wraps silently in both directions
  a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && push && sp_r == 3'h7 |=> sp_r == 3'h0)
    else $error("stack pointer did not wrap on push");
  a_ptr_under: assert property (@(posedge clk_sys) disable iff (!arst_n)
    ce && pop && !push && sp_r == 3'h0 |=> sp_r == 3'h7)
    else $error("stack pointer did not wrap on pop");
endmodule
`default_nettype wire

// *** pcsi_core_tb.sv ***
// self-checking testbench for the program counter, stack and indirect unit
`timescale 1ns/1ps
`default_nettype none
module pcsi_core_tb;
  import pcsi_pkg::*;
  logic clk_sys;
  logic arst_n;
  logic ce;
  pcsi_flow_type flow;
  pcsi_wr_type wr;
  pcsi_ind_type ind;
  logic [7:0] ind_target_rdata;
  logic [12:0] pc_r;
  logic [7:0] low_r;
  logic [7:0] latch_r;
  logic [7:0] ptr_r;
  logic bank_r;
  logic [8:0] iaddr_r;
  logic rd_en_r;
  logic wr_en_r;
  logic [7:0] rdata_r;
  int error_cnt;
  int n_tests;
  logic [12:0] stk [1:9];

  pcsi_core dut_u
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .flow(flow),
    .wr(wr),
    .ind(ind),
    .ind_target_rdata(ind_target_rdata),
    .pc_r(pc_r),
    .pc_low_byte_register_r(low_r),
    .pc_high_latch_r(latch_r),
    .file_select_pointer_r(ptr_r),
    .indirect_bank_select_r(bank_r),
    .ind_addr_r(iaddr_r),
    .ind_rd_en_r(rd_en_r),
    .ind_wr_en_r(wr_en_r),
    .ind_rdata_r(rdata_r)
  );

  // clock generator
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  // one instruction cycle, inputs move 1 ns after the edge
  task automatic cyc();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic op_step(input pcsi_op_type op, input logic [10:0] t);
    flow.op = op;
    flow.target = t;
    cyc();
  endtask

  task automatic wstep(input logic [3:0] we, input logic [7:0] d);
    wr = {we, d};
    cyc();
  endtask

  task automatic ind_step(input logic [1:0] rw, input logic [7:0] td);
    ind = rw;
    ind_target_rdata = td;
    cyc();
  endtask

  task automatic t_reset();
    chk("pc", pc_r, 13'h0000);
    chk("latch", 13'(latch_r), 13'h0000);
    $display("test reset done");
  endtask

  task automatic t_seq();
    repeat (3) op_step(PCSI_OP_NEXT, 11'h000);
    chk("pc", pc_r, 13'h0003);
    chk("low", 13'(low_r), 13'h0003);
    ce = 1'b0;
    op_step(PCSI_OP_NEXT, 11'h000);
    chk("frozen", pc_r, 13'h0003);
    ce = 1'b1;
    $display("test seq done");
  endtask

  task automatic t_low();
    flow.op = PCSI_OP_NEXT;
    wstep(4'b0100, 8'h1d);
    wstep(4'b1000, 8'hff);
    chk("pc", pc_r, 13'h1dff);
    wstep(4'b0000, 8'h00);
    chk("carry", pc_r, 13'h1e00);
    chk("low", 13'(low_r), 13'h0000);
    wstep(4'b1000, 8'h03);
    chk("table", pc_r, 13'h1d03);
    $display("test low done");
  endtask

  task automatic t_flow();
    wstep(4'b0100, 8'h18);
    wstep(4'b0000, 8'h00);
    op_step(PCSI_OP_JUMP, 11'h123);
    chk("jump", pc_r, 13'h1923);
    op_step(PCSI_OP_CALL, 11'h055);
    chk("call", pc_r, 13'h1855);
    chk("latch", 13'(latch_r), 13'h0018);
    op_step(PCSI_OP_RET, 11'h000);
    chk("ret", pc_r, 13'h1924);
    flow.op = PCSI_OP_NEXT;
    wstep(4'b0100, 8'h00);
    op_step(PCSI_OP_CALL, 11'h7ff);
    chk("call page0", pc_r, 13'h07ff);
    op_step(PCSI_OP_RETLIT, 11'h000);
    chk("retlit", pc_r, 13'h1926);
    op_step(PCSI_OP_INTVEC, 11'h000);
    chk("vector", pc_r, 13'h0004);
    op_step(PCSI_OP_RETINT, 11'h000);
    chk("retint", pc_r, 13'h1926);
    $display("test flow done");
  endtask

  task automatic t_wrap();
    flow.op = PCSI_OP_HOLD;
    wstep(4'b1100, 8'h00);
    wstep(4'b0000, 8'h00);
    for (int i = 1; i <= 9; i++)
    begin
      stk[i] = (i == 1) ? 13'h0001 : 13'((i - 1) * 16 + 1);
      op_step(PCSI_OP_CALL, 11'(i * 16));
    end
    for (int j = 1; j <= 9; j++)
    begin
      op_step(PCSI_OP_RET, 11'h000);
      chk("pop", pc_r, (j == 9) ? stk[9] : stk[10 - j]);
    end
    $display("test wrap done");
  endtask

  task automatic t_ind();
    flow.op = PCSI_OP_HOLD;
    wstep(4'b0010, 8'h35);
    wstep(4'b0001, 8'h01);
    ind_step(2'b10, 8'ha5);
    chk("addr", 13'(iaddr_r), 13'h0135);
    chk("ptr", 13'(ptr_r), 13'h0035);
    chk("bank", 13'(bank_r), 13'h0001);
    chk("rd_en", 13'(rd_en_r), 13'h0001);
    chk("rdata", 13'(rdata_r), 13'h00a5);
    wstep(4'b0001, 8'h00);
    ind_step(2'b01, 8'h5a);
    chk("addr", 13'(iaddr_r), 13'h0035);
    chk("wr_en", 13'(wr_en_r), 13'h0001);
    wstep(4'b0010, 8'h00);
    ind_step(2'b10, 8'h77);
    chk("self rd", 13'(rdata_r), 13'h0000);
    chk("self rd_en", 13'(rd_en_r), 13'h0000);
    ind_step(2'b01, 8'h77);
    chk("self wr_en", 13'(wr_en_r), 13'h0000);
    ind_step(2'b00, 8'h00);
    $display("test ind done");
  endtask

  // reset in mid-run clears the counter and the latch
  task automatic t_rst_mid();
    wstep(4'b0100, 8'h1f);
    wstep(4'b1000, 8'h00);
    chk("pc pre", pc_r, 13'h1f00);
    wr = '0;
    arst_n = 1'b0;
    cyc();
    chk("pc rst", pc_r, 13'h0000);
    chk("latch rst", 13'(latch_r), 13'h0000);
    arst_n = 1'b1;
    op_step(PCSI_OP_NEXT, 11'h000);
    chk("pc after", pc_r, 13'h0001);
    $display("test mid reset done");
  endtask

  // watchdog against a hung run
  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  // reset then the scenarios in turn
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    flow = '{op: PCSI_OP_HOLD, target: 11'h000, vector: 13'h0004};
    wr = '0;
    ind = '0;
    ind_target_rdata = 8'h00;
    repeat (20) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    t_reset();
    t_seq();
    t_low();
    t_flow();
    t_wrap();
    t_ind();
    t_rst_mid();
    tally_and_finish();
  end
endmodule
`default_nettype wire
